// *** inc/dpm_pkg.sv ***
package dpm_pkg;
   // Power modes held by the controller
   typedef enum logic [1:0] {
      DPM_ACTIVE,
      DPM_IDLE,
      DPM_STANDBY,
      DPM_SLEEP
   } dpm_mode_t;

   // Host command codes presented on the command port
   localparam logic [2:0] CMD_IDLE = 3'h0;
   localparam logic [2:0] CMD_IDLE_IMM = 3'h1;
   localparam logic [2:0] CMD_STANDBY = 3'h2;
   localparam logic [2:0] CMD_STANDBY_IMM = 3'h3;
   localparam logic [2:0] CMD_SLEEP = 3'h4;
   localparam logic [2:0] CMD_CHECK = 3'h5;
   localparam logic [2:0] CMD_OTHER = 3'h6;

   // Timer count width and the disabling value
   localparam int TMR_W = 8;
   localparam logic [7:0] TMR_OFF = 8'h00;

   // Length of one timer count, in microseconds
   localparam int TICK_US = 5;
   localparam int CLK_MHZ = 125;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;

   // Spindle spin-up time, in microseconds
   localparam int SPIN_US = 20;
   localparam int SPIN_CYC = SPIN_US * CLK_MHZ;

   // Check power mode answers
   localparam logic [1:0] PWR_IN_STANDBY = 2'h0;
   localparam logic [1:0] PWR_ENTERING = 2'h1;
   localparam logic [1:0] PWR_LEAVING = 2'h2;
   localparam logic [1:0] PWR_ACTIVE_IDLE = 2'h3;
endpackage

// *** logic/dpm_tick.sv ***
// Divider giving a one-cycle tick every DIV clocks while running
module dpm_tick
#(
   parameter int DIV = 625
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic restart,
   output logic tick
);
   localparam int CW = $clog2(DIV + 1);

   // Cycle counter within the current tick
   logic [CW-1:0] cnt_q;

   // Restart realigns the tick to the last command
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         tick <= 1'b0;
      end
      else if (restart)
      begin
         cnt_q <= '0;
         tick <= 1'b0;
      end
      else if (cnt_q == CW'(DIV - 1))
      begin
         cnt_q <= '0;
         tick <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// *** logic/dpm_ctrl.sv ***
// Notes on behaviour
// - Idle commands move directly to idle
// - Idle loads timer count and starts it
// - Standby commands move directly to standby
// - Standby command also loads timer count
// - Sleep command ends with interface inactive
// - Reset out of sleep lands in standby
// - Timer expiry without commands, media requests or cache work forces standby
// - Timer count zero disables the timer
// - Check power reports standby state transitions
// - Busy low, ready high outside active
// - Ready never encodes the power mode
// - Standby accepts commands, delays media until spun
// - Idle serves media at once
// - Cache work means active mode; executing means active until command done or timer expiry
module dpm_ctrl
#(
   parameter int TICK_CYCLES = dpm_pkg::TICK_CYC,
   parameter int SPIN_CYCLES = dpm_pkg::SPIN_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic [7:0] cmd_count,
   input wire logic cmd_done,
   input wire logic media_req,
   input wire logic bg_busy,
   output logic cmd_ack,
   output logic [1:0] pwr_status,
   output logic status_bsy,
   output logic status_rdy,
   output logic if_active,
   output logic media_on,
   output logic media_grant,
   output dpm_pkg::dpm_mode_t mode
);
   import dpm_pkg::*;

   localparam int SW = $clog2(SPIN_CYCLES + 1);

   // Mode state and held timer setting
   dpm_mode_t mode_q, mode_d;
   logic [TMR_W-1:0] tmr_load_q;
   logic [TMR_W-1:0] tmr_cnt_q;
   logic tmr_run_q;
   logic [SW-1:0] spin_q;
   logic busy_q;
   logic tick;

   // Command decode
   wire acc = cmd_valid && (mode_q != DPM_SLEEP);
   wire c_idle = acc && (cmd_code == CMD_IDLE || cmd_code == CMD_IDLE_IMM);
   wire c_stby = acc && (cmd_code == CMD_STANDBY || cmd_code == CMD_STANDBY_IMM);
   wire c_load = acc && (cmd_code == CMD_IDLE || cmd_code == CMD_STANDBY);
   wire c_sleep = acc && cmd_code == CMD_SLEEP;
   wire c_check = acc && cmd_code == CMD_CHECK;
   wire c_other = acc && cmd_code == CMD_OTHER;
   wire spinning = spin_q != '0;
   // Last spin-up cycle: the spindle is at speed, media may be served next
   wire spun = spin_q == SW'(1);
   wire expire = tmr_run_q && tick && tmr_cnt_q == 8'h01;
   wire awake = mode_q == DPM_ACTIVE || mode_q == DPM_IDLE;

   // Tick divider; any command restarts the inactivity period
   dpm_tick #(.DIV(TICK_CYCLES)) u_tick
   (
      .clk(clk),
      .rst(rst),
      .restart(acc),
      .tick(tick)
   );

   // Next mode selection
   always_comb
   begin
      mode_d = mode_q;
      case (mode_q)
         DPM_SLEEP:
            mode_d = DPM_SLEEP;
         default:
         begin
            if (c_idle)
               mode_d = DPM_IDLE;
            else if (c_stby)
               mode_d = DPM_STANDBY;
            else if (c_sleep)
               mode_d = DPM_SLEEP;
            else if (c_other || (media_req && !spinning && mode_q != DPM_STANDBY)
                     || bg_busy)
               mode_d = DPM_ACTIVE;
            else if (awake && expire)
               mode_d = DPM_STANDBY;
            else if (mode_q == DPM_ACTIVE && !busy_q && !bg_busy)
               mode_d = DPM_IDLE;
            else if (mode_q == DPM_STANDBY && spun)
               mode_d = DPM_ACTIVE;
         end
      endcase
   end

   // Mode register; reset lands in standby, also out of sleep
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mode_q <= DPM_STANDBY;
      else
         mode_q <= mode_d;
   end

   // Command busy tracker: set on other commands, cleared on done
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         busy_q <= 1'b0;
      else if (c_other)
         busy_q <= 1'b1;
      else if (cmd_done)
         busy_q <= 1'b0;
   end

   // Standby timer; zero count disables it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tmr_load_q <= TMR_OFF;
         tmr_cnt_q <= TMR_OFF;
         tmr_run_q <= 1'b0;
      end
      else if (c_load)
      begin
         tmr_load_q <= cmd_count;
         tmr_cnt_q <= cmd_count;
         tmr_run_q <= (cmd_count != TMR_OFF);
      end
      else if (acc)
      begin
         tmr_cnt_q <= tmr_load_q;
         tmr_run_q <= tmr_load_q != TMR_OFF;
      end
      else if (!awake)
         tmr_run_q <= 1'b0;
      else if (tmr_load_q != TMR_OFF && !tmr_run_q)
      begin
         tmr_cnt_q <= tmr_load_q;
         tmr_run_q <= 1'b1;
      end
      else if (expire)
         tmr_run_q <= 1'b0;
      else if (tmr_run_q && tick)
         tmr_cnt_q <= tmr_cnt_q - 1'b1;
   end

   // Spin-up delay: media requests in standby wait for spindle speed
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         spin_q <= '0;
      else if (mode_q == DPM_STANDBY && media_req && !spinning)
         spin_q <= SW'(SPIN_CYCLES);
      else if (spinning && mode_q != DPM_SLEEP)
         spin_q <= spin_q - 1'b1;
      else
         spin_q <= '0;
   end

   wire leave = (mode_q == DPM_STANDBY) && spinning;
   // Entering: inactivity period on its last count, so standby comes next;
   // a standby command itself switches at once and leaves nothing to report
   wire enter = awake && tmr_run_q && tmr_cnt_q == TMR_W'(1);
   wire [1:0] pwr_d = enter ? PWR_ENTERING :
                      leave ? PWR_LEAVING :
                      (mode_q == DPM_STANDBY) ? PWR_IN_STANDBY : PWR_ACTIVE_IDLE;

   // Registered status outputs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmd_ack <= 1'b0;
         pwr_status <= PWR_IN_STANDBY;
         status_bsy <= 1'b0;
         status_rdy <= 1'b1;
         if_active <= 1'b1;
         media_on <= 1'b0;
         media_grant <= 1'b0;
         mode <= DPM_STANDBY;
      end
      else
      begin
         cmd_ack <= acc;
         if (c_check)
            pwr_status <= pwr_d;
         status_bsy <= (mode_d == DPM_ACTIVE) && (busy_q || c_other);
         status_rdy <= 1'b1;
         if_active <= mode_d != DPM_SLEEP;
         media_on <= mode_d == DPM_ACTIVE || mode_d == DPM_IDLE;
         media_grant <= media_req && awake;
         mode <= mode_d;
      end
   end

   // Checks
   a_sleep_sticky: assert property (@(posedge clk) disable iff (rst)
      mode_q == DPM_SLEEP |=> mode_q == DPM_SLEEP)
      else $error("sleep left without reset");
   a_idle_cmd: assert property (@(posedge clk) disable iff (rst)
      c_idle |=> mode_q == DPM_IDLE && mode == DPM_IDLE)
      else $error("idle command missed");
   a_stby_cmd: assert property (@(posedge clk) disable iff (rst)
      c_stby |=> mode_q == DPM_STANDBY)
      else $error("standby command missed");
   a_sleep_if: assert property (@(posedge clk) disable iff (rst)
      c_sleep |=> ##1 !if_active)
      else $error("interface active in sleep");
   a_timer_load: assert property (@(posedge clk) disable iff (rst)
      c_load |=> tmr_load_q == $past(cmd_count))
      else $error("timer count not loaded");
   a_timer_zero: assert property (@(posedge clk) disable iff (rst)
      c_load && cmd_count == 8'h00 |=> !tmr_run_q)
      else $error("zero count left timer running");
   a_expire_stby: assert property (@(posedge clk) disable iff (rst)
      expire && awake && !acc && !bg_busy && !media_req |=> mode_q == DPM_STANDBY)
      else $error("timer expiry ignored");
   a_rdy_low_pwr: assert property (@(posedge clk) disable iff (rst)
      mode_q != DPM_ACTIVE && $past(mode_q) != DPM_ACTIVE |-> status_rdy && !status_bsy)
      else $error("status wrong outside active");
   a_check_stby: assert property (@(posedge clk) disable iff (rst)
      c_check && mode_q == DPM_STANDBY && !spinning |=> pwr_status == PWR_IN_STANDBY)
      else $error("check power answer wrong");
   a_stby_no_grant: assert property (@(posedge clk) disable iff (rst)
      mode_q == DPM_STANDBY |=> !media_grant)
      else $error("media granted in standby");
   c_sleep_seen: cover property (@(posedge clk) mode_q == DPM_SLEEP);
   c_enter_seen: cover property (@(posedge clk) c_check && enter);
   c_expire_seen: cover property (@(posedge clk) expire && awake);
   c_spin_seen: cover property (@(posedge clk) leave);
endmodule

// *** tb/dpm_host.sv ***
// Host model: one command per call, driven off the falling edge
module dpm_host
(
   input wire logic clk,
   input wire logic cmd_ack,
   output logic cmd_valid,
   output logic [2:0] cmd_code,
   output logic [7:0] cmd_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acked; // Ack seen for the last command
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = 3'h7;
      cmd_count = 8'hff;
      acked = 1'b0;
   end
   // Strobe spans one rising edge, then the fields go stale on purpose
   task automatic send(input logic [2:0] c, input logic [7:0] n);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_count = n;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_code = ~c; // Stale code must not be reused
      cmd_count = ~n;
      acked = cmd_ack;
      repeat (2) @(negedge clk) acked = acked | cmd_ack;
   endtask
endmodule

// *** tb/drive_power_mode_controller_tb.sv ***
// Counts every compare and reports a mismatch at once
`define CHK(g, e) \
   begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module drive_power_mode_controller_tb
   import dpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_done = 1'b0; // Other command finished
   logic media_req = 1'b0;
   logic bg_busy = 1'b0; // Look-ahead or cache work
   logic cmd_valid, cmd_ack, status_bsy, status_rdy, if_active, media_on, media_grant;
   logic [2:0] cmd_code;
   logic [7:0] cmd_count;
   logic [1:0] pwr_status;
   dpm_mode_t mode;
   int checks = 0;
   int bad_count = 0;

   always #4 clk = ~clk;

   // Short tick and spin so timer runs stay brief
   dpm_ctrl #(.TICK_CYCLES(4), .SPIN_CYCLES(8)) dut_u (.clk(clk), .rst(rst),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_count(cmd_count),
      .cmd_done(cmd_done), .media_req(media_req), .bg_busy(bg_busy),
      .cmd_ack(cmd_ack), .pwr_status(pwr_status), .status_bsy(status_bsy),
      .status_rdy(status_rdy), .if_active(if_active), .media_on(media_on),
      .media_grant(media_grant), .mode(mode));

   dpm_host host_u (.clk(clk), .cmd_ack(cmd_ack), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_count(cmd_count));

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Only a reset leaves sleep; it must land in standby
   task automatic t_reset();
      rst = 1'b1;
      wt(8);
      rst = 1'b0;
      wt(1);
      `CHK(mode, DPM_STANDBY)
      `CHK({status_bsy, status_rdy, if_active, media_on}, 4'h6)
      $display("reset test done");
   endtask

   // Count zero disables the timer; idle serves media at once
   task automatic t_idle();
      host_u.send(CMD_IDLE, 8'h00);
      `CHK(host_u.acked, 1'b1)
      `CHK({mode, media_on, status_bsy, status_rdy}, {DPM_IDLE, 3'h5})
      media_req = 1'b1;
      wt(2);
      `CHK(media_grant, 1'b1)
      media_req = 1'b0;
      wt(40);
      `CHK(mode, DPM_IDLE)
      $display("idle test done");
   endtask

   // Immediate forms switch modes; check reports the state
   task automatic t_mode();
      host_u.send(CMD_STANDBY_IMM, 8'h05);
      `CHK({mode, media_on, if_active}, {DPM_STANDBY, 2'h1})
      host_u.send(CMD_CHECK, 8'h00);
      `CHK(pwr_status, PWR_IN_STANDBY)
      host_u.send(CMD_IDLE_IMM, 8'h00);
      `CHK(mode, DPM_IDLE)
      host_u.send(CMD_CHECK, 8'h00);
      `CHK(pwr_status, PWR_ACTIVE_IDLE)
      host_u.send(CMD_IDLE, 8'h01);
      host_u.send(CMD_CHECK, 8'h00);
      `CHK(pwr_status, PWR_ENTERING)
      $display("mode test done");
   endtask

   // Timer loaded by idle and by standby forces standby on expiry
   task automatic t_timer();
      host_u.send(CMD_IDLE, 8'h02);
      `CHK(mode, DPM_IDLE)
      wt(20);
      `CHK(mode, DPM_STANDBY)
      host_u.send(CMD_STANDBY, 8'h03);
      host_u.send(CMD_IDLE_IMM, 8'h00);
      `CHK(mode, DPM_IDLE)
      wt(20);
      `CHK(mode, DPM_STANDBY)
      $display("timer test done");
   endtask

   // Media in standby waits for spin-up, then work keeps it active
   task automatic t_spin();
      media_req = 1'b1;
      wt(2);
      `CHK(media_grant, 1'b0)
      host_u.send(CMD_CHECK, 8'h00);
      `CHK(pwr_status, PWR_LEAVING)
      wt(16);
      `CHK({mode, media_grant}, {DPM_ACTIVE, 1'b1})
      media_req = 1'b0;
      bg_busy = 1'b1;
      wt(4);
      `CHK({mode, status_rdy}, {DPM_ACTIVE, 1'b1})
      bg_busy = 1'b0;
      wt(4);
      `CHK(mode, DPM_IDLE)
      host_u.send(CMD_OTHER, 8'h00);
      `CHK({mode, status_bsy}, {DPM_ACTIVE, 1'b1})
      cmd_done = 1'b1;
      wt(1);
      cmd_done = 1'b0;
      wt(3);
      `CHK({mode, status_bsy}, {DPM_IDLE, 1'b0})
      $display("spin test done");
   endtask

   // Sleep drops the interface and refuses commands
   task automatic t_sleep();
      host_u.send(CMD_SLEEP, 8'h00);
      `CHK({mode, if_active, media_on, status_rdy}, {DPM_SLEEP, 3'h1})
      host_u.send(CMD_IDLE_IMM, 8'h00);
      `CHK({host_u.acked, mode}, {1'b0, DPM_SLEEP})
      t_reset();
      $display("sleep test done");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Whole run is under two hundred cycles; this bound is generous
   initial
   begin
      #20000;
      bad_count++;
      stop_test();
   end

   initial
   begin
      t_reset();
      t_idle();
      t_mode();
      t_timer();
      t_spin();
      t_sleep();
      stop_test();
   end
endmodule
